// [common/cst_pkg.sv]
// cst_pkg: register map, codes and timing constants for the cyclic sense timers
package cst_pkg;

  // register map, 7-bit register addresses
  localparam logic [6:0] ADDR_FILT = 7'h09;
  localparam logic [6:0] ADDR_TMR1 = 7'h0c;
  localparam logic [6:0] ADDR_TMR2 = 7'h0d;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] FILT_MASK = 8'h3f;
  localparam logic [7:0] TMR_MASK = 8'h77;

  // field layout
  localparam int FLT_FIELD_W = 2;
  localparam int CODE_W = 3;
  localparam int ON_LSB = 4;
  localparam int PER_LSB = 0;

  // filter, on-time and switch codes
  localparam logic [1:0] FLT_STATIC_SHORT = 2'h0;
  localparam logic [1:0] FLT_STATIC_LONG = 2'h1;
  localparam logic [1:0] FLT_CYCLIC_T1 = 2'h2;
  localparam logic [1:0] FLT_CYCLIC_T2 = 2'h3;
  localparam logic [2:0] ON_STOP_LOW = 3'h0;
  localparam logic [2:0] ON_STOP_HIGH = 3'h6;
  localparam logic [2:0] CODE_RESERVED = 3'h7;
  localparam logic [2:0] HS_ON = 3'h1;
  localparam logic [2:0] HS_TIMER1 = 3'h2;
  localparam logic [2:0] HS_TIMER2 = 3'h3;

  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int NS_PER_US = 1000;
  localparam int US_PER_MS = 1000;
  localparam int FILT_SHORT_NS = 16000;
  localparam int FILT_LONG_NS = 64000;
  localparam int TICK_US = 100;
  localparam int FILT_SHORT_CYCLES = (FILT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_LONG_CYCLES = (FILT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_CYCLES = (TICK_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int ON_1_US = 100;
  localparam int ON_2_US = 300;
  localparam int ON_3_US = 1000;
  localparam int ON_4_US = 10000;
  localparam int ON_5_US = 20000;
  localparam int PER_0_MS = 10;
  localparam int PER_1_MS = 20;
  localparam int PER_2_MS = 50;
  localparam int PER_3_MS = 100;
  localparam int PER_4_MS = 200;
  localparam int PER_5_MS = 1000;
  localparam int PER_6_MS = 2000;

  localparam int TICK_W = 15;
  typedef logic [TICK_W-1:0] cst_ticks_type;

  function automatic cst_ticks_type cst_us_to_ticks(input int us);
    return cst_ticks_type'(us / TICK_US);
  endfunction

  function automatic cst_ticks_type cst_on_ticks(input logic [2:0] code);
    case (code)
      3'h1: return cst_us_to_ticks(ON_1_US);
      3'h2: return cst_us_to_ticks(ON_2_US);
      3'h3: return cst_us_to_ticks(ON_3_US);
      3'h4: return cst_us_to_ticks(ON_4_US);
      3'h5: return cst_us_to_ticks(ON_5_US);
      default: return '0;
    endcase
  endfunction

  function automatic cst_ticks_type cst_per_ticks(input logic [2:0] code);
    case (code)
      3'h0: return cst_us_to_ticks(PER_0_MS * US_PER_MS);
      3'h1: return cst_us_to_ticks(PER_1_MS * US_PER_MS);
      3'h2: return cst_us_to_ticks(PER_2_MS * US_PER_MS);
      3'h3: return cst_us_to_ticks(PER_3_MS * US_PER_MS);
      3'h4: return cst_us_to_ticks(PER_4_MS * US_PER_MS);
      3'h5: return cst_us_to_ticks(PER_5_MS * US_PER_MS);
      3'h6: return cst_us_to_ticks(PER_6_MS * US_PER_MS);
      default: return '0;
    endcase
  endfunction

  function automatic logic cst_is_cyclic(input logic [1:0] code);
    return (code == FLT_CYCLIC_T1) || (code == FLT_CYCLIC_T2);
  endfunction

endpackage

// [common/cst_timer_if.sv]
// cst_timer_if: settings and events between the top and one cyclic timer
`timescale 1ns/100ps
interface cst_timer_if;
  logic tick;
  logic [2:0] on_code;
  logic [2:0] per_code;
  logic out;
  logic on_end;
  logic per_start;
  modport ctrl (output tick, output on_code, output per_code,
                input out, input on_end, input per_start);
  modport timer (input tick, input on_code, input per_code,
                 output out, output on_end, output per_start);
endinterface

// [design/cst_cyclic_timer.sv]
// cst_cyclic_timer: one cyclic timer counting base ticks over period and on-time
`timescale 1ns/100ps
module cst_cyclic_timer (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // settings and events
  cst_timer_if.timer tif
);
  import cst_pkg::*;

  cst_ticks_type cnt_q;
  cst_ticks_type cnt_d;
  cst_ticks_type on_len;
  cst_ticks_type per_len;
  logic out_q;
  logic on_end_q;
  logic per_start_q;
  logic run_q;
  wire running;
  wire started;
  wire step;
  wire hold_high;
  wire last_tick;
  wire out_d;

  // reserved codes stop the timer with its output low
  assign running = (tif.on_code != ON_STOP_LOW) && (tif.on_code != ON_STOP_HIGH) &&
                   (tif.on_code != CODE_RESERVED) && (tif.per_code != CODE_RESERVED);
  assign hold_high = (tif.on_code == ON_STOP_HIGH);
  assign on_len = cst_on_ticks(tif.on_code);
  assign per_len = cst_per_ticks(tif.per_code);
  // >= rather than == so a shortened period still wraps
  assign last_tick = (cnt_q >= per_len - 1'b1);
  // the start cycle ignores a tick, so the first on-time is never swallowed
  assign started = running && run_q;
  assign step = started && tif.tick;
  assign cnt_d = !started ? '0 : (!step ? cnt_q : (last_tick ? '0 : cnt_q + 1'b1));
  assign out_d = running ? (cnt_d < on_len) : hold_high;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      out_q <= 1'b0;
      on_end_q <= 1'b0;
      per_start_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
      // an on-time as long as the period never falls, so it gives no sample
      on_end_q <= step && !last_tick && (cnt_q == on_len - 1'b1);
      per_start_q <= step && last_tick;
      run_q <= running;
    end
  end

  assign tif.out = out_q;
  assign tif.on_end = on_end_q;
  assign tif.per_start = per_start_q;

  property p_stop_low;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (tif.on_code == ON_STOP_LOW) |=> !tif.out;
  endproperty
  a_stop_low: assert property (p_stop_low) else $error("stopped timer output not low");

  property p_stop_high;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (tif.on_code == ON_STOP_HIGH) |=> tif.out;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("held timer output not high");

  property p_start_high;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(running) |=> tif.out && (cnt_q == '0);
  endproperty
  a_start_high: assert property (p_start_high) else $error("timer did not start high");

  property p_on_end_fall;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    tif.on_end |-> !tif.out && $past(tif.out);
  endproperty
  a_on_end_fall: assert property (p_on_end_fall) else $error("on-time end without fall");

  property p_period_high;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    tif.per_start |-> tif.out && (cnt_q == '0);
  endproperty
  a_period_high: assert property (p_period_high) else $error("period start not high");
endmodule

// [design/cst_wake_timer_top.sv]
// cst_wake_timer_top: filter select, two cyclic timers and wake filtering
`timescale 1ns/100ps
module cst_wake_timer_top #(
  parameter int FILT_SHORT = cst_pkg::FILT_SHORT_CYCLES,
  parameter int FILT_LONG = cst_pkg::FILT_LONG_CYCLES,
  parameter int TICK_LEN = cst_pkg::TICK_CYCLES,
  parameter int FCNT_W = 14,
  parameter int PRE_W = 15,
  parameter int HS_COUNT = 4
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // device mode events
  input wire logic soft_reset_i,
  input wire logic restart_hs_clear_i,
  // register access
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // wake inputs
  input wire logic first_wake_input_i,
  input wire logic second_wake_input_i,
  input wire logic third_wake_input_i,
  // wake source enables and switch configuration
  input wire logic first_timer_wake_enable_i,
  input wire logic second_timer_wake_enable_i,
  input wire logic [cst_pkg::CODE_W*HS_COUNT-1:0] hs_config_i,
  // outputs
  output logic [HS_COUNT-1:0] high_side_output_o,
  output logic [2:0] wake_level_o,
  output logic [2:0] wake_change_o,
  output logic [1:0] timer_wake_o
);
  import cst_pkg::*;

  localparam int NUM_WAKE = 3;
  localparam logic [FCNT_W-1:0] SHORT_CNT = FCNT_W'(FILT_SHORT);
  localparam logic [FCNT_W-1:0] LONG_CNT = FCNT_W'(FILT_LONG);
  localparam logic [PRE_W-1:0] TICK_LAST = PRE_W'(TICK_LEN - 1);

  logic [7:0] filt_q;
  logic [7:0] filt_d;
  logic [7:0] tmr1_q;
  logic [7:0] tmr1_d;
  logic [7:0] tmr2_q;
  logic [7:0] tmr2_d;
  logic [7:0] rdata_d;
  logic [PRE_W-1:0] pre_q;
  logic tick_q;
  logic [NUM_WAKE-1:0] in_q;
  logic [NUM_WAKE-1:0] level_q;
  logic [NUM_WAKE-1:0] change_q;
  logic [NUM_WAKE-1:0] accept;
  logic [FCNT_W-1:0] stab_q [NUM_WAKE];
  logic [HS_COUNT-1:0] hs_d;
  logic [1:0] twake_d;

  wire [NUM_WAKE-1:0] wake_in;
  wire sel_filt;
  wire sel_tmr1;
  wire sel_tmr2;
  wire wr_filt;
  wire wr_tmr1;
  wire wr_tmr2;
  wire cyclic_sel;
  wire clr_timers;
  wire tick_wrap;

  cst_timer_if t1_if ();
  cst_timer_if t2_if ();

  // register decode
  assign sel_filt = (reg_addr_i == ADDR_FILT);
  assign sel_tmr1 = (reg_addr_i == ADDR_TMR1);
  assign sel_tmr2 = (reg_addr_i == ADDR_TMR2);
  assign wr_filt = reg_wr_i && sel_filt;
  assign wr_tmr1 = reg_wr_i && sel_tmr1;
  assign wr_tmr2 = reg_wr_i && sel_tmr2;

  // cyclic sensing counts as selected while any input uses a timer
  assign cyclic_sel = cst_is_cyclic(filt_q[1:0]) ||
                      cst_is_cyclic(filt_q[3:2]) ||
                      cst_is_cyclic(filt_q[5:4]);
  // clearing beats a write in the same cycle, it acts like a reset
  assign clr_timers = soft_reset_i || (restart_hs_clear_i && cyclic_sel);

  assign filt_d = soft_reset_i ? REG_RESET :
                  (wr_filt ? (reg_wdata_i & FILT_MASK) : filt_q);
  assign tmr1_d = clr_timers ? REG_RESET :
                  (wr_tmr1 ? (reg_wdata_i & TMR_MASK) : tmr1_q);
  assign tmr2_d = clr_timers ? REG_RESET :
                  (wr_tmr2 ? (reg_wdata_i & TMR_MASK) : tmr2_q);

  // masks keep reserved bits zero, unmapped addresses read zero
  assign rdata_d = sel_filt ? (filt_q & FILT_MASK) :
                   sel_tmr1 ? (tmr1_q & TMR_MASK) :
                   sel_tmr2 ? (tmr2_q & TMR_MASK) : REG_RESET;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filt_q <= REG_RESET;
      tmr1_q <= REG_RESET;
      tmr2_q <= REG_RESET;
      reg_rdata_o <= REG_RESET;
    end else begin
      filt_q <= filt_d;
      tmr1_q <= tmr1_d;
      tmr2_q <= tmr2_d;
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_d;
      end
    end
  end

  // one shared base tick keeps both timers on the same time grid
  assign tick_wrap = (pre_q >= TICK_LAST);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_q <= '0;
      tick_q <= 1'b0;
    end else begin
      pre_q <= tick_wrap ? '0 : pre_q + 1'b1;
      tick_q <= tick_wrap;
    end
  end

  assign t1_if.tick = tick_q;
  assign t1_if.on_code = tmr1_q[ON_LSB +: CODE_W];
  assign t1_if.per_code = tmr1_q[PER_LSB +: CODE_W];
  assign t2_if.tick = tick_q;
  assign t2_if.on_code = tmr2_q[ON_LSB +: CODE_W];
  assign t2_if.per_code = tmr2_q[PER_LSB +: CODE_W];

  cst_cyclic_timer u_timer1 (
    .core_clk_i (core_clk_i),
    .rst_n_i (rst_n_i),
    .tif (t1_if.timer)
  );

  cst_cyclic_timer u_timer2 (
    .core_clk_i (core_clk_i),
    .rst_n_i (rst_n_i),
    .tif (t2_if.timer)
  );

  // wake filtering per input
  assign wake_in = {third_wake_input_i, second_wake_input_i, first_wake_input_i};

  for (genvar g = 0; g < NUM_WAKE; g++) begin : g_wake
    wire [1:0] mode;
    wire [FCNT_W-1:0] thr;
    wire stable;
    wire strobe;

    assign mode = filt_q[g*FLT_FIELD_W +: FLT_FIELD_W];
    assign thr = (mode == FLT_STATIC_LONG) ? LONG_CNT : SHORT_CNT;
    assign stable = (stab_q[g] >= thr);
    // a cyclic input only samples when its timer ends an on-time
    assign strobe = (mode == FLT_CYCLIC_T1) ? t1_if.on_end :
                    (mode == FLT_CYCLIC_T2) ? t2_if.on_end : 1'b1;
    assign accept[g] = strobe && stable && (in_q[g] != level_q[g]);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        stab_q[g] <= '0;
      end else if (wake_in[g] != in_q[g]) begin
        stab_q[g] <= '0;
      end else if (stab_q[g] < LONG_CNT) begin
        stab_q[g] <= stab_q[g] + 1'b1;
      end
    end

    property p_static_short;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      change_q[g] && ($past(mode) == FLT_STATIC_SHORT) |->
        ($past(stab_q[g]) >= SHORT_CNT) && (wake_level_o[g] == $past(in_q[g]));
    endproperty
    a_static_short: assert property (p_static_short) else $error("short filter early");

    property p_static_long;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      change_q[g] && ($past(mode) == FLT_STATIC_LONG) |-> $past(stab_q[g]) >= LONG_CNT;
    endproperty
    a_static_long: assert property (p_static_long) else $error("long filter early");

    property p_cyclic_t1;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      change_q[g] && ($past(mode) == FLT_CYCLIC_T1) |->
        $past(t1_if.on_end) && ($past(stab_q[g]) >= SHORT_CNT);
    endproperty
    a_cyclic_t1: assert property (p_cyclic_t1) else $error("sample off first timer");

    property p_cyclic_t2;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      change_q[g] && ($past(mode) == FLT_CYCLIC_T2) |-> $past(t2_if.on_end);
    endproperty
    a_cyclic_t2: assert property (p_cyclic_t2) else $error("sample off second timer");
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_q <= '0;
      level_q <= '0;
      change_q <= '0;
    end else begin
      in_q <= wake_in;
      level_q <= level_q ^ accept;
      change_q <= accept;
    end
  end

  // switch outputs follow their configured source
  for (genvar k = 0; k < HS_COUNT; k++) begin : g_hs
    wire [CODE_W-1:0] code;
    assign code = hs_config_i[k*CODE_W +: CODE_W];
    assign hs_d[k] = (code == HS_ON) ||
                     ((code == HS_TIMER1) && t1_if.out) ||
                     ((code == HS_TIMER2) && t2_if.out);
  end

  // cyclic wake uses its own enable, so sensing keeps running beside it
  assign twake_d = {t2_if.per_start && second_timer_wake_enable_i,
                    t1_if.per_start && first_timer_wake_enable_i};

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      high_side_output_o <= '0;
      timer_wake_o <= '0;
    end else begin
      high_side_output_o <= hs_d;
      timer_wake_o <= twake_d;
    end
  end

  assign wake_level_o = level_q;
  assign wake_change_o = change_q;

  property p_filt_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_filt && !soft_reset_i |=> filt_q == ($past(reg_wdata_i) & FILT_MASK);
  endproperty
  a_filt_write: assert property (p_filt_write) else $error("filter select not stored");

  property p_rsv_filt;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $past(reg_rd_i && sel_filt) |-> (reg_rdata_o & ~FILT_MASK) == REG_RESET;
  endproperty
  a_rsv_filt: assert property (p_rsv_filt) else $error("filter reserved bits set");

  property p_rsv_tmr;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $past(reg_rd_i && (sel_tmr1 || sel_tmr2)) |-> (reg_rdata_o & ~TMR_MASK) == REG_RESET;
  endproperty
  a_rsv_tmr: assert property (p_rsv_tmr) else $error("timer reserved bits set");

  property p_soft_reset;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    soft_reset_i |=> (filt_q == REG_RESET) && (tmr1_q == REG_RESET) && (tmr2_q == REG_RESET);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset left a value");

  property p_restart_clear;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    restart_hs_clear_i && cyclic_sel |=> (tmr1_q == REG_RESET) && (tmr2_q == REG_RESET);
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("restart kept timers");

  property p_restart_keep;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    restart_hs_clear_i && !cyclic_sel && !soft_reset_i && !reg_wr_i |=> $stable(tmr1_q);
  endproperty
  a_restart_keep: assert property (p_restart_keep) else $error("timer cleared wrongly");

  property p_hs_timer1;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (hs_config_i[CODE_W-1:0] == HS_TIMER1) |=> high_side_output_o[0] == $past(t1_if.out);
  endproperty
  a_hs_timer1: assert property (p_hs_timer1) else $error("switch not on first timer");

  property p_hs_timer2;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (hs_config_i[CODE_W-1:0] == HS_TIMER2) |=> high_side_output_o[0] == $past(t2_if.out);
  endproperty
  a_hs_timer2: assert property (p_hs_timer2) else $error("switch not on second timer");

  property p_timer_wake;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    timer_wake_o[0] |-> $past(first_timer_wake_enable_i) && $past(t1_if.per_start);
  endproperty
  a_timer_wake: assert property (p_timer_wake) else $error("wake without enable");

  property p_wake_with_sense;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    t2_if.per_start && second_timer_wake_enable_i |=> timer_wake_o[1];
  endproperty
  a_wake_with_sense: assert property (p_wake_with_sense) else $error("cyclic wake lost");
endmodule

// [testbench/cst_switch_model.sv]
// cst_switch_model: external switches powered from the high-side outputs
`timescale 1ns/100ps
module cst_switch_model (
  // switch supply from the device
  input wire logic [3:0] high_side_output_i,
  // contact state chosen by the bench
  input wire logic [2:0] switch_closed_i,
  // wake pins back to the device
  output logic [2:0] wake_pin_o
);
  // an unpowered switch lets the pin sink to its pull-down, whatever the contact
  assign wake_pin_o = switch_closed_i & high_side_output_i[2:0];
endmodule

// [testbench/tb_cst_wake_timer_top.sv]
// tb_cst_wake_timer_top: scenario bench for the cyclic sense timers and filters
`timescale 1ns/100ps
module tb_cst_wake_timer_top;
  import cst_pkg::*;
  localparam int FS = 8;
  localparam int FL = 16;
  localparam int TK = 20;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic soft_reset_i = 1'b0;
  logic restart_hs_clear_i = 1'b0;
  logic [6:0] reg_addr_i = 7'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [2:0] wake_pin;
  logic [2:0] closed = 3'h0;
  logic [1:0] wk_en = 2'h0;
  logic [11:0] hs_config_i = 12'h000;
  logic [3:0] high_side_output_o;
  logic [2:0] wake_level_o;
  logic [2:0] wake_change_o;
  logic [1:0] timer_wake_o;
  int fails = 0;
  int check_count = 0;

  cst_wake_timer_top #(.FILT_SHORT(FS), .FILT_LONG(FL), .TICK_LEN(TK)) i_cst_wake_timer_top (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .soft_reset_i(soft_reset_i),
    .restart_hs_clear_i(restart_hs_clear_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .first_wake_input_i(wake_pin[0]),
    .second_wake_input_i(wake_pin[1]), .third_wake_input_i(wake_pin[2]),
    .first_timer_wake_enable_i(wk_en[0]), .second_timer_wake_enable_i(wk_en[1]),
    .hs_config_i(hs_config_i), .high_side_output_o(high_side_output_o),
    .wake_level_o(wake_level_o), .wake_change_o(wake_change_o), .timer_wake_o(timer_wake_o));

  cst_switch_model i_cst_switch_model (
    .high_side_output_i(high_side_output_o), .switch_closed_i(closed), .wake_pin_o(wake_pin));

  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic strobe(ref logic s);
    @(negedge core_clk_i);
    s = 1'b1;
    @(negedge core_clk_i);
    s = 1'b0;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e, input string m);
    @(negedge core_clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    chk(reg_rdata_o === e, m);
  endtask

  // bounded wait until switch k shows level v, n counts the cycles spent
  task automatic wait_hs(input int k, input logic v, output int n);
    n = 0;
    while (high_side_output_o[k] !== v && n < 30000) begin
      @(negedge core_clk_i);
      n++;
    end
  endtask

  task automatic meas(input int k, input int on_c, input int per_c);
    int h;
    int p;
    wait_hs(k, 1'b0, h);
    wait_hs(k, 1'b1, h);
    wait_hs(k, 1'b0, h);
    wait_hs(k, 1'b1, p);
    chk(h == on_c, "on-time width");
    chk(h + p == per_c, "period length");
  endtask

  task automatic t_regs;
    rd(ADDR_FILT, 8'h00, "filter reset value");
    rd(ADDR_TMR1, 8'h00, "timer one reset value");
    rd(ADDR_TMR2, 8'h00, "timer two reset value");
    wr(ADDR_FILT, 8'hff);
    rd(ADDR_FILT, 8'h3f, "filter reserved bits");
    wr(ADDR_TMR1, 8'hff);
    rd(ADDR_TMR1, 8'h77, "timer one reserved bits");
    wr(ADDR_TMR2, 8'hff);
    rd(ADDR_TMR2, 8'h77, "timer two reserved bits");
    wr(7'h0a, 8'h5a);
    rd(7'h0a, 8'h00, "unmapped read");
    // static filters only: a restart clear must leave the timers alone
    wr(ADDR_FILT, 8'h00);
    wr(ADDR_TMR1, 8'h15);
    strobe(restart_hs_clear_i);
    rd(ADDR_TMR1, 8'h15, "restart clear without cyclic sensing");
    strobe(soft_reset_i);
    rd(ADDR_FILT, 8'h00, "filter after soft reset");
    rd(ADDR_TMR1, 8'h00, "timer one after soft reset");
    rd(ADDR_TMR2, 8'h00, "timer two after soft reset");
  endtask

  task automatic t_timers;
    hs_config_i = {6'h00, HS_TIMER2, HS_TIMER1};
    wr(ADDR_TMR1, 8'h10);
    wr(ADDR_TMR2, 8'h21);
    meas(0, TK, 100 * TK);
    meas(1, 3 * TK, 200 * TK);
    wr(ADDR_TMR1, 8'h32);
    meas(0, 10 * TK, 500 * TK);
  endtask

  task automatic t_stop;
    hs_config_i = {HS_TIMER2, 3'h0, HS_TIMER2, HS_TIMER2};
    wr(ADDR_TMR2, 8'h60);
    idle(3 * TK);
    chk(high_side_output_o === 4'hb, "stop high");
    wr(ADDR_TMR2, 8'h00);
    idle(3 * TK);
    chk(high_side_output_o === 4'h0, "stop low");
    wr(ADDR_TMR2, 8'h70);
    idle(3 * TK);
    chk(high_side_output_o === 4'h0, "reserved on-time runs");
    wr(ADDR_TMR1, 8'h00);
  endtask

  task automatic t_filt(input int k, input logic [1:0] code, input int thr);
    int n;
    hs_config_i = 12'h049;
    wr(ADDR_FILT, {6'h00, code} << (2 * k));
    closed[k] = 1'b1;
    idle(thr - 4);
    closed[k] = 1'b0;
    idle(thr + 8);
    chk(wake_level_o[k] === 1'b0, "short pulse accepted");
    closed[k] = 1'b1;
    n = 0;
    while (wake_level_o[k] !== 1'b1 && n < 200) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(wake_change_o[k] === 1'b1, "no change pulse with new level");
    chk(n > thr && n <= thr + 4, "static filter delay");
    closed[k] = 1'b0;
    idle(thr + 8);
    chk(wake_level_o[k] === 1'b0, "release not accepted");
  endtask

  task automatic t_cyc(input int k, input logic [1:0] code, input logic [2:0] hsc, input int j);
    int n;
    hs_config_i = {9'h000, hsc} << (3 * k);
    wr(ADDR_FILT, {6'h00, code} << (2 * k));
    wr(ADDR_TMR1, 8'h10);
    wr(ADDR_TMR2, 8'h10);
    wk_en[j] = 1'b1;
    // close only in an off-time, so the first sample sees a whole on-time
    wait_hs(k, 1'b1, n);
    wait_hs(k, 1'b0, n);
    closed[k] = 1'b1;
    wait_hs(k, 1'b1, n);
    idle(FS + 6);
    chk(wake_level_o[k] === 1'b0, "sampled before on-time end");
    n = 0;
    while (wake_level_o[k] !== 1'b1 && n < 2 * TK) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(n <= TK, "no sample at on-time end");
    n = 0;
    repeat (100 * TK) begin
      @(negedge core_clk_i);
      n += timer_wake_o[j];
    end
    chk(n == 1, "timer wake count while sensing");
    wk_en[j] = 1'b0;
    n = 0;
    repeat (100 * TK) begin
      @(negedge core_clk_i);
      n += timer_wake_o[j];
    end
    chk(n == 0, "timer wake while disabled");
    strobe(restart_hs_clear_i);
    rd(ADDR_TMR1, 8'h00, "timer one kept after restart clear");
    rd(ADDR_TMR2, 8'h00, "timer two kept after restart clear");
    idle(4);
    chk(high_side_output_o[k] === 1'b0, "switch still driven after clear");
    closed[k] = 1'b0;
    wr(ADDR_FILT, 8'h00);
    idle(FL + 8);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // the full sequence needs about 45k cycles, the limit leaves margin
  initial begin
    #450000;
    fails++;
    $display("MISMATCH %0t run did not finish in time", $time);
    wrap_up();
  end

  initial begin
    idle(20);
    rst_n_i = 1'b1;
    t_regs();
    t_timers();
    t_stop();
    t_filt(0, FLT_STATIC_SHORT, FS);
    t_filt(1, FLT_STATIC_LONG, FL);
    t_filt(2, FLT_STATIC_SHORT, FS);
    t_cyc(0, FLT_CYCLIC_T1, HS_TIMER1, 0);
    t_cyc(2, FLT_CYCLIC_T2, HS_TIMER2, 1);
    wrap_up();
  end
endmodule
